//--- hw/ssc_capture.sv
`timescale 1ns/10ps
module ssc_capture
  import ssc_pkg::*;
#(
  parameter int PIPE_D = PIPE_DEPTH
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_CLK-1:0] tgt_clk,
  input wire logic [NUM_QUAL-1:0] tgt_qual,
  input wire logic [NUM_GRP*GRP_W-1:0] tgt_data,
  output logic acq_write,
  output logic [NUM_GRP*GRP_W-1:0] acq_data
);

  function automatic logic edge_fn(ssc_ed_type c, logic [NUM_CLK-1:0] now, logic [NUM_CLK-1:0] prev);
    logic rise;
    logic fall;
    rise = now[c.src] & ~prev[c.src];
    fall = ~now[c.src] & prev[c.src];
    return (c.edge_mode[0] & rise) | (c.edge_mode[1] & fall);
  endfunction

  function automatic logic [1:0] src_of(logic [1:0] g, ssc_mode_type m, logic both, logic [1:0] dmx);
    if (m == SSC_MODE_QUAD)
      return 2'h0;
    else if (m == SSC_MODE_HS)
      return both ? {1'b0, g[0]} : g;
    else if (dmx == DMX_FOUR)
      return 2'h0;
    else if (dmx == DMX_TWO)
      return {g[1], 1'b0};
    else
      return g;
  endfunction

  // Registers
  logic [1:0] mode_bits;
  logic [1:0] xedge;
  logic enable;
  ssc_ed_type [NUM_ED-1:0] ed_reg;
  logic [NUM_CG-1:0][NUM_ED-1:0] cg_reg;
  ssc_sc_type [NUM_SC-1:0] sc_reg;
  ssc_grp_type grp_reg [NUM_GRP];
  logic [NUM_GRP-1:0][1:0] dmx_reg;
  logic ovf;
  logic [15:0] sample_cnt;

  // Synchronisers and history
  logic [NUM_CLK-1:0] clk_s1, clk_s2, clk_s3;
  logic [NUM_QUAL-1:0] qual_s1, qual_s2;
  logic [NUM_GRP*GRP_W-1:0] d_s1, d_s2, d_s3, d_s4;

  // Capture state
  ssc_csm_type clocking_state_machine;
  logic [NUM_ED-1:1] seen;
  logic [GRP_W-1:0] latch [NUM_GRP];
  logic [GRP_W-1:0] pipe [NUM_GRP][PIPE_D];
  logic [1:0] ph;
  logic [2:0] pend_cnt;
  logic [1:0] pend_g;

  wire ssc_mode_type mode = ssc_mode_type'(mode_bits);
  wire logic both = (xedge == EDGE_BOTH);
  wire logic is_src = enable && (mode == SSC_MODE_SRC);
  wire logic is_hs = enable && (mode == SSC_MODE_HS);
  wire logic is_quad = enable && (mode == SSC_MODE_QUAD);

  // APB decode
  wire logic apb_wr = psel && penable && pwrite;
  wire logic apb_setup = psel && !penable;
  wire logic is_grp = (paddr[7:4] == OFS_GRP0[7:4]);
  wire logic [1:0] grp_idx = paddr[3:2];
  wire logic mapped = (paddr[1:0] == 2'h0) && (is_grp || paddr == OFS_CTRL || paddr == OFS_EDGE ||
    paddr == OFS_CGRP || paddr == OFS_SCLK || paddr == OFS_DEMUX || paddr == OFS_STATUS);
  wire logic wr_ctrl = apb_wr && (paddr == OFS_CTRL);
  wire logic wr_stat = apb_wr && (paddr == OFS_STATUS);
  wire logic [31:0] rd_val =
    (paddr == OFS_CTRL) ? {27'h0, enable, xedge, mode_bits} :
    (paddr == OFS_EDGE) ? {16'h0, ed_reg} :
    (paddr == OFS_CGRP) ? {20'h0, cg_reg} :
    (paddr == OFS_SCLK) ? {2'h0, sc_reg[3], 2'h0, sc_reg[2], 2'h0, sc_reg[1], 2'h0, sc_reg[0]} :
    (is_grp && mapped) ? {18'h0, grp_reg[grp_idx]} :
    (paddr == OFS_DEMUX) ? {24'h0, dmx_reg} :
    (paddr == OFS_STATUS) ? {sample_cnt, 14'h0, (clocking_state_machine == SSC_CSM_RUN), ovf} :
    32'h0;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (apb_setup)
      prdata <= rd_val;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_bits <= 2'h0;
      xedge <= EDGE_RISE;
      enable <= 1'b0;
      ed_reg <= '0;
      cg_reg <= '0;
      sc_reg <= '0;
      dmx_reg <= '0;
      for (int i = 0; i < NUM_GRP; i++)
        grp_reg[i] <= '0;
    end
    else if (apb_wr && mapped)
    begin
      if (paddr == OFS_CTRL)
      begin
        mode_bits <= pwdata[CTRL_MODE_LSB +: 2];
        xedge <= pwdata[CTRL_EDGE_LSB +: 2];
        enable <= pwdata[CTRL_ENABLE];
      end
      if (paddr == OFS_EDGE)
        ed_reg <= pwdata[15:0];
      if (paddr == OFS_CGRP)
        cg_reg <= pwdata[11:0];
      if (paddr == OFS_SCLK)
        for (int s = 0; s < NUM_SC; s++)
          sc_reg[s] <= pwdata[8*s +: 6];
      if (is_grp)
        grp_reg[grp_idx] <= pwdata[13:0];
      if (paddr == OFS_DEMUX)
        dmx_reg <= pwdata[7:0];
      if (wr_ctrl && pwdata[CTRL_DMX_ALL])
        dmx_reg <= {NUM_GRP{DMX_TWO}};
      if (wr_ctrl && pwdata[CTRL_DMX_NONE])
        dmx_reg <= '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_s1 <= '0;
      clk_s2 <= '0;
      clk_s3 <= '0;
      qual_s1 <= '0;
      qual_s2 <= '0;
      d_s1 <= '0;
      d_s2 <= '0;
      d_s3 <= '0;
      d_s4 <= '0;
    end
    else
    begin
      clk_s1 <= tgt_clk;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      qual_s1 <= tgt_qual;
      qual_s2 <= qual_s1;
      d_s1 <= tgt_data;
      d_s2 <= d_s1;
      d_s3 <= d_s2;
      d_s4 <= d_s3;
    end
  end

  // Edge detectors, clock groups and sample clock equations
  logic [NUM_ED-1:0] ed_hit;
  logic [NUM_ED-1:0] have;
  logic [NUM_CG-1:0] cg_done;
  logic [NUM_SC-1:0] sc_true;
  for (genvar d = 0; d < NUM_ED; d++)
  begin : g_ed
    assign ed_hit[d] = edge_fn(ed_reg[d], clk_s2, clk_s3);
  end
  wire logic heartbeat = is_src && ed_hit[0];
  assign have = {seen | ed_hit[NUM_ED-1:1], heartbeat};
  for (genvar c = 0; c < NUM_CG; c++)
  begin : g_cg
    assign cg_done[c] = heartbeat && (|cg_reg[c]) && (&(have | ~cg_reg[c]));
  end
  for (genvar s = 0; s < NUM_SC; s++)
  begin : g_sc
    assign sc_true[s] = (|(sc_reg[s].groups & cg_done)) && (&(qual_s2 | ~sc_reg[s].qual));
  end
  wire logic gc_any = |cg_done;
  wire logic commit = (clocking_state_machine == SSC_CSM_RUN) && heartbeat && gc_any;
  wire logic strobe_ovf = is_src && !heartbeat && |(ed_hit[NUM_ED-1:1] & seen);

  // Per-group data paths
  logic [GRP_W-1:0] win_data [NUM_GRP];
  logic [GRP_W-1:0] delayed [NUM_GRP];
  logic [NUM_GRP-1:0] grp_sc_ok;
  logic [NUM_GRP-1:0] strobe_cap;
  for (genvar g = 0; g < NUM_GRP; g++)
  begin : g_grp
    wire logic [1:0] src = src_of(2'(g), mode, both, dmx_reg[g]);
    wire logic common = (mode == SSC_MODE_SRC) && (grp_reg[g].edsel == 2'h0);
    wire logic [1:0] win = common ? WIN_CENTRE : grp_reg[g].window;
    assign win_data[g] = (win == WIN_EARLY) ? d_s4[GRP_W*src +: GRP_W] :
                         (win == WIN_LATE) ? d_s2[GRP_W*src +: GRP_W] :
                         d_s3[GRP_W*src +: GRP_W];
    assign delayed[g] = (grp_reg[g].delay == 3'h0) ? latch[g] : pipe[g][grp_reg[g].delay - 3'h1];
    assign grp_sc_ok[g] = sc_true[grp_reg[g].sclk];
    assign strobe_cap[g] = is_src && (common ? heartbeat : ed_hit[grp_reg[g].edsel]);
  end

  // Fast external modes
  wire ssc_ed_type xcfg = '{edge_mode: xedge, src: 2'h0};
  wire logic x_hit = (is_hs || is_quad) && edge_fn(xcfg, clk_s2, clk_s3);
  wire logic [NUM_GRP-1:0] hs_mask = !(is_hs && x_hit) ? 4'h0 : !both ? 4'hf : ph[0] ? 4'hc : 4'h3;
  wire logic hs_wr = is_hs && x_hit && (!both || ph[0]);
  wire logic q_now = is_quad && x_hit && (!ph[0] || grp_reg[ph].skew == 3'h0);
  wire logic q_arm = is_quad && x_hit && ph[0] && grp_reg[ph].skew != 3'h0;
  wire logic q_pend = is_quad && (pend_cnt == 3'h1);
  wire logic [NUM_GRP-1:0] q_mask = (q_now ? 4'(1 << ph) : 4'h0) | (q_pend ? 4'(1 << pend_g) : 4'h0);
  wire logic q_wr = (q_now && ph == 2'h3) || (q_pend && pend_g == 2'h3);
  wire logic [NUM_GRP-1:0] src_mask = commit ? grp_sc_ok : 4'h0;
  wire logic [NUM_GRP-1:0] cap_mask = hs_mask | q_mask | src_mask;
  wire logic next_write = hs_wr || q_wr || (commit && |grp_sc_ok);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clocking_state_machine <= SSC_CSM_IDLE;
    else
    begin
      case (clocking_state_machine)
        SSC_CSM_IDLE: if (is_src) clocking_state_machine <= SSC_CSM_RUN;
        SSC_CSM_RUN: if (!is_src) clocking_state_machine <= SSC_CSM_IDLE;
        default: clocking_state_machine <= SSC_CSM_IDLE;
      endcase
    end
  end

  // Strobe arrivals held until a completing heartbeat consumes them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      seen <= '0;
    else if (!is_src)
      seen <= '0;
    else if (commit)
      seen <= '0;
    else
      seen <= seen | ed_hit[NUM_ED-1:1];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ovf <= 1'b0;
    else if (strobe_ovf)
      ovf <= 1'b1;
    else if (wr_stat && pwdata[STAT_OVF])
      ovf <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int g = 0; g < NUM_GRP; g++)
      begin
        latch[g] <= '0;
        for (int k = 0; k < PIPE_D; k++)
          pipe[g][k] <= '0;
      end
    else
      for (int g = 0; g < NUM_GRP; g++)
      begin
        if (strobe_cap[g])
          latch[g] <= win_data[g];
        if (commit)
        begin
          pipe[g][0] <= latch[g];
          for (int k = 1; k < PIPE_D; k++)
            pipe[g][k] <= pipe[g][k-1];
        end
      end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph <= 2'h0;
      pend_cnt <= 3'h0;
      pend_g <= 2'h0;
    end
    else
    begin
      if (!(is_hs || is_quad))
        ph <= 2'h0;
      else if (x_hit)
        ph <= is_hs ? {1'b0, ~ph[0]} : ph + 2'h1;
      if (q_arm)
      begin
        pend_cnt <= grp_reg[ph].skew;
        pend_g <= ph;
      end
      else if (pend_cnt != 3'h0)
        pend_cnt <= pend_cnt - 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acq_write <= 1'b0;
      acq_data <= '0;
      sample_cnt <= 16'h0;
    end
    else
    begin
      acq_write <= next_write;
      if (next_write)
        sample_cnt <= sample_cnt + 16'h1;
      for (int g = 0; g < NUM_GRP; g++)
        if (cap_mask[g])
          acq_data[GRP_W*g +: GRP_W] <= is_src ? delayed[g] : win_data[g];
    end
  end

  sequence s_strobe1;
    is_src && ed_hit[1] && !commit;
  endsequence

  sequence s_hb_miss;
    heartbeat && !gc_any;
  endsequence

  AST_SRC_WRITE_EQ: assert property (@(posedge pclk) disable iff (!presetn)
    (is_src && acq_write) |-> $past(commit) && $past(|grp_sc_ok))
    else $error("write without true sample clock");
  AST_NO_ADV_NO_GC: assert property (@(posedge pclk) disable iff (!presetn)
    s_hb_miss ##0 is_src ##0 $stable(mode_bits) |=> !acq_write)
    else $error("advanced without group complete");
  AST_STRADDLE_HELD: assert property (@(posedge pclk) disable iff (!presetn)
    s_strobe1 ##1 (is_src && !commit) |-> seen[1])
    else $error("straddling strobe lost");
  AST_HB_SOURCE: assert property (@(posedge pclk) disable iff (!presetn)
    commit |-> (ed_reg[0].edge_mode[0] && clk_s2[ed_reg[0].src] && !clk_s3[ed_reg[0].src]) ||
      (ed_reg[0].edge_mode[1] && !clk_s2[ed_reg[0].src] && clk_s3[ed_reg[0].src]))
    else $error("commit not on heartbeat");
  AST_HS_HALF: assert property (@(posedge pclk) disable iff (!presetn)
    (is_hs && both && x_hit && !ph[0]) |=> !acq_write ##0 ph[0])
    else $error("both-edge mode wrote on first edge");
  AST_HS_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    (is_hs && acq_write && $stable(mode_bits)) |-> $past(x_hit))
    else $error("high-speed write without edge");
  AST_QUAD_LAST: assert property (@(posedge pclk) disable iff (!presetn)
    (is_quad && acq_write && $stable(mode_bits)) |-> $past(cap_mask[3]))
    else $error("quad write before fourth capture");
  AST_OVF_SET: assert property (@(posedge pclk) disable iff (!presetn)
    strobe_ovf |=> ovf [*2])
    else $error("overflow not flagged");
  AST_PIPE_SHIFT: assert property (@(posedge pclk) disable iff (!presetn)
    commit |=> pipe[0][0] == $past(latch[0]) && pipe[1][1] == $past(pipe[1][0]))
    else $error("pipeline stage not advanced");
  AST_RESET_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(presetn) |-> seen == '0 && ph == 2'h0 && pend_cnt == 3'h0 && !acq_write)
    else $error("state not cleared by reset");

endmodule

//--- hw/ssc_pkg.sv
// Functional notes
// - Quad-rate mode trades three quarters of channels for speed and four times depth.
// - Quad-rate mode accepts clocks to 625 MHz and data to 1.25 GB/s.
// - Quad-rate mode is double data rate: two samples per driving clock cycle.
// - Quad-rate groups get edge choice, data alignment and a second-edge skew delay.
// - High-speed mode samples on rising, falling or both target clock edges.
// - High-speed both-edge mode: 235 MHz, 470 Mb/s, half the channels given up.
// - Sender aligns data to strobe; device latches by strobe, resyncs to heartbeat.
// - Edge detector 0 is the heartbeat clocking state machine and completion logic.
// - Four edge detectors, each picks one of four inputs, rise/fall/both.
// - Three clock groups, each a selectable subset of the four edge detectors.
// - Four sample clocks, each OR of clock groups ANDed with three qualifiers.
// - Each channel group selects detector, window, delay and sample clock; its clock group field is stored but unused.
// - Groups demultiplex two or four ways; select-all and clear-all controls exist.
// - Same channels sampled at two pipeline delays via demultiplexed pairs.
// - Common-clock groups always use a window centred on that clock.
// - Clocking state machine advances only after group complete is asserted.
// - Strobe straddling a heartbeat edge is registered on the next heartbeat.
// - Source-synchronous memory write only on cycles where the sample clock equation is true.
// - Quad-rate modes make three quarters of channels demultiplex destinations.
package ssc_pkg;

  localparam int NUM_ED = 4;
  localparam int NUM_CLK = 4;
  localparam int NUM_CG = 3;
  localparam int NUM_SC = 4;
  localparam int NUM_QUAL = 3;
  localparam int NUM_GRP = 4;
  localparam int GRP_W = 8;
  localparam int PIPE_DEPTH = 7;

  // Documented rate limits of the capture modes
  localparam int QUAD_MAX_CLK_MHZ = 625;
  localparam int QUAD_MAX_RATE_MBYTE = 1250;
  localparam int HS_DDR_MAX_CLK_MHZ = 235;
  localparam int HS_DDR_MAX_RATE_MBIT = 470;
  localparam int TGT_EDGE_SEP_FAST_PS = 2200;
  localparam int TGT_EDGE_SEP_SLOW_PS = 4200;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_EDGE = 8'h04;
  localparam logic [7:0] OFS_CGRP = 8'h08;
  localparam logic [7:0] OFS_SCLK = 8'h0c;
  localparam logic [7:0] OFS_GRP0 = 8'h10;
  localparam logic [7:0] OFS_DEMUX = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_EDGE_LSB = 2;
  localparam int CTRL_ENABLE = 4;
  localparam int CTRL_DMX_ALL = 8;
  localparam int CTRL_DMX_NONE = 9;
  localparam int STAT_OVF = 0;
  localparam int STAT_GC = 1;
  localparam int STAT_CNT_LSB = 16;

  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] WIN_EARLY = 2'h0;
  localparam logic [1:0] WIN_CENTRE = 2'h1;
  localparam logic [1:0] WIN_LATE = 2'h2;
  localparam logic [1:0] DMX_NONE = 2'h0;
  localparam logic [1:0] DMX_TWO = 2'h1;
  localparam logic [1:0] DMX_FOUR = 2'h2;

  typedef enum logic [1:0] {
    SSC_MODE_HS = 2'b00,
    SSC_MODE_QUAD = 2'b01,
    SSC_MODE_SRC = 2'b10
  } ssc_mode_type;

  typedef enum logic [1:0] {
    SSC_CSM_IDLE = 2'b00,
    SSC_CSM_RUN = 2'b01
  } ssc_csm_type;

  typedef struct packed {
    logic [1:0] edge_mode;
    logic [1:0] src;
  } ssc_ed_type;

  typedef struct packed {
    logic [2:0] qual;
    logic [2:0] groups;
  } ssc_sc_type;

  typedef struct packed {
    logic [2:0] skew;
    logic [1:0] sclk;
    logic [1:0] cgrp;
    logic [1:0] edsel;
    logic [1:0] window;
    logic [2:0] delay;
  } ssc_grp_type;

endpackage

//--- verif/ssc_tgt_model.sv
`timescale 1ns/10ps
module ssc_tgt_model
  import ssc_pkg::*;
(
  input wire logic run,
  input wire logic fast,
  input wire logic strobe_on,
  input wire logic [NUM_QUAL-1:0] qual,
  input wire logic [NUM_GRP*GRP_W-1:0] pat,
  output logic [NUM_CLK-1:0] tgt_clk,
  output logic [NUM_QUAL-1:0] tgt_qual,
  output logic [NUM_GRP*GRP_W-1:0] tgt_data
);
  logic hb;
  logic stb;
  logic [GRP_W-1:0] cnt;

  // Unused clock inputs idle low
  assign tgt_clk = {2'b00, stb, hb};
  assign tgt_qual = qual;
  // Data changes with each strobe edge
  assign tgt_data = pat ^ {NUM_GRP{cnt}};

  // Heartbeat, 160 ns period, stands still while not running
  initial
  begin
    hb = 1'b0;
    #7;
    forever
    begin
      #80;
      if (run)
        hb = ~hb;
    end
  end

  // Strobe edges sit 40 ns away from heartbeat edges, one edge per heartbeat period; with fast set, one edge every 30 ns
  initial
  begin
    stb = 1'b0;
    cnt = '0;
    #47;
    forever
    begin
      if (fast)
        #30;
      else
        #160;
      if (strobe_on)
      begin
        stb = ~stb;
        cnt = cnt + 8'h01;
      end
      else
        cnt = '0;
    end
  end
endmodule

//--- verif/test_ssc_capture.sv
`timescale 1ns/10ps
module test_ssc_capture
  import ssc_pkg::*;
;
  logic pclk;
  logic presetn;
  logic [7:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NUM_CLK-1:0] tgt_clk;
  logic [NUM_QUAL-1:0] tgt_qual;
  logic [NUM_GRP*GRP_W-1:0] tgt_data;
  logic acq_write;
  logic [NUM_GRP*GRP_W-1:0] acq_data;
  logic run;
  logic fast;
  logic strobe_on;
  logic [NUM_QUAL-1:0] qual;
  logic counting;
  logic last_err;
  logic [31:0] q;
  logic [31:0] last_data;
  int wr_count;
  int num_errors;
  int check_count;
  localparam logic [31:0] PAT = 32'h3c5a96e1;

  ssc_capture i_ssc_capture (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tgt_clk(tgt_clk),
    .tgt_qual(tgt_qual), .tgt_data(tgt_data), .acq_write(acq_write), .acq_data(acq_data));

  ssc_tgt_model i_ssc_tgt_model (.run(run), .fast(fast), .strobe_on(strobe_on), .qual(qual), .pat(PAT),
    .tgt_clk(tgt_clk), .tgt_qual(tgt_qual), .tgt_data(tgt_data));

  initial
  begin
    pclk = 1'b0;
  end

  always #10 pclk = ~pclk;

  // Counts memory writes inside a measuring window
  always @(posedge pclk)
  begin
    if (counting && acq_write === 1'b1)
    begin
      wr_count <= wr_count + 1;
      last_data <= acq_data;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  // Runs the heartbeat for ten periods and counts the writes that result
  task automatic run_window(input logic s, input logic q0);
    @(posedge pclk);
    wr_count = 0;
    counting <= 1'b1;
    run <= 1'b1;
    strobe_on <= s;
    qual <= {2'b00, q0};
    // Strobe stops one heartbeat period early so no strobe is left uncommitted
    repeat (72) @(posedge pclk);
    strobe_on <= 1'b0;
    repeat (8) @(posedge pclk);
    run <= 1'b0;
    repeat (12) @(posedge pclk);
    counting <= 1'b0;
  endtask

  initial
  begin
    presetn = 1'b0;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h00000000;
    run = 1'b0;
    fast = 1'b0;
    strobe_on = 1'b0;
    qual = 3'h0;
    counting = 1'b0;
    wr_count = 0;
    num_errors = 0;
    check_count = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, OFS_CTRL, 32'h0, q);
    check("ctrl reset", q, 32'h00000004);
    xfer(1'b0, OFS_STATUS, 32'h0, q);
    check("status reset", q, 32'h00000000);
    xfer(1'b0, 8'h28, 32'h0, q);
    check("unmapped read", {last_err, q[30:0]}, 32'h80000000);
    // High-speed mode: rise, fall, both edges
    wr(OFS_CTRL, 32'h00000014);
    run_window(1'b0, 1'b0);
    check("rise writes", wr_count, 32'd10);
    check("rise data", last_data, PAT);
    wr(OFS_CTRL, 32'h00000018);
    run_window(1'b0, 1'b0);
    check("fall writes", wr_count, 32'd10);
    wr(OFS_CTRL, 32'h0000001c);
    run_window(1'b0, 1'b0);
    check("both writes", wr_count, 32'd10);
    check("both data", last_data, {PAT[15:0], PAT[15:0]});
    // Source-synchronous: heartbeat on input 0, strobe on input 1
    wr(OFS_EDGE, 32'h000000d4);
    wr(OFS_CGRP, 32'h00000003);
    wr(OFS_SCLK, 32'h00000009);
    wr(OFS_GRP0, 32'h00000028);
    wr(OFS_CTRL, 32'h00000016);
    run_window(1'b1, 1'b0);
    check("qualifier low writes", wr_count, 32'd0);
    run_window(1'b0, 1'b1);
    check("no strobe writes", wr_count, 32'd0);
    run_window(1'b1, 1'b1);
    check("strobe writes", 32'(wr_count >= 8 && wr_count <= 10), 32'd1);
    xfer(1'b0, OFS_STATUS, 32'h0, q);
    check("no overflow", {31'b0, q[0]}, 32'h0);
    fast <= 1'b1;
    run_window(1'b1, 1'b1);
    fast <= 1'b0;
    xfer(1'b0, OFS_STATUS, 32'h0, q);
    check("overflow set", {31'b0, q[0]}, 32'h1);
    wr(OFS_STATUS, 32'h00000001);
    xfer(1'b0, OFS_STATUS, 32'h0, q);
    check("overflow cleared", {31'b0, q[0]}, 32'h0);
    fast <= 1'b1;
    run_window(1'b1, 1'b1);
    fast <= 1'b0;
    do_reset();
    xfer(1'b0, OFS_STATUS, 32'h0, q);
    check("status after reset", q, 32'h00000000);
    // Quad-rate: both edges fill the four groups from group 0 channels
    wr(OFS_CTRL, 32'h0000001d);
    run_window(1'b0, 1'b0);
    check("quad writes", wr_count, 32'd5);
    check("quad data", last_data, {4{PAT[7:0]}});
    wr(OFS_CTRL, 32'h00000104);
    xfer(1'b0, OFS_DEMUX, 32'h0, q);
    check("demux all", q, 32'h00000055);
    wr(OFS_CTRL, 32'h00000304);
    xfer(1'b0, OFS_DEMUX, 32'h0, q);
    check("demux clear", q, 32'h00000000);
    wr(OFS_DEMUX, 32'h000000aa);
    xfer(1'b0, OFS_DEMUX, 32'h0, q);
    check("demux four", q, 32'h000000aa);
    wr(OFS_GRP0, 32'h00003fff);
    xfer(1'b0, OFS_GRP0, 32'h0, q);
    check("group config", q, 32'h00003fff);
    give_verdict();
  end

  initial
  begin
    #400000;
    num_errors++;
    $display("Error watchdog expected done seen hang");
    give_verdict();
  end
endmodule
